// ### ccrt_card.sv
// Purpose: Card end: decodes host commands and answers on the command line.
// Assumes: The host makes the bus clock and keeps it running during busy.
// Notes: Link logic runs on the bus clock; user ports run on clock.
//
// Contract
// - Launch every bit on the rising edge.
// - Identification answers open-drain after exact delay.
// - Address assignment answers open-drain, minimum delay.
// - After address, push-pull drive of command line.
// - Two released bits, then pull-ups, before answer.
// - Busy pulls data zero low two cycles on.
// - Host waits answer-to-command gap before next.
// - Host waits command-to-command gap before next.
// - No answer within delay plus one: no card.
// - Start zero, end one, transmitter bit per sender.
// - Seven bit check field on every frame; op-condition answer sends all ones, long answer none.
// - Pull-up driven high, released high, pull-down low.
// - Byte is the unit; block lengths whole bytes.
// - Erase group size from legacy or extended data.
// - Protect group counted in erase groups, same selection.
// - Host may ignore status bits of unsupported classes.
`timescale 1ns/1ps
`default_nettype none
module ccrt_card
  import ccrt_pkg::*;
#(
  parameter int BLOCK_LEN = 512,
  parameter logic [31:0] OP_COND_WORD = 32'h80ff8000,
  // Identification content; value is arbitrary
  parameter logic [126:0] IDENT_WORD = 127'h1234_5678_9abc_def0_1357_9bdf_2468_ace0,
  parameter logic [15:0] LEG_EG_SIZE = 16'h0001,
  parameter logic [15:0] EXT_EG_SIZE = 16'h0001,
  parameter logic [15:0] LEG_WP_SIZE = 16'h0001,
  parameter logic [15:0] EXT_WP_SIZE = 16'h0001
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic busy_req,
  input wire logic erase_group_select,
  output logic cmd_strobe,
  output logic [5:0] cmd_index_out,
  output logic [31:0] cmd_arg_out,
  output logic [15:0] rel_addr_out,
  output logic transfer_mode,
  output logic [15:0] erase_group_size,
  output logic [15:0] wp_group_size,
  ccrt_link_if.card lk
);
  typedef enum logic [1:0] {CCRT_C_RX, CCRT_C_DELAY, CCRT_C_TX,
    CCRT_C_QUIET} ccrt_card_state_e;

  initial begin
    if (BLOCK_LEN < 1) begin
      $error("BLOCK_LEN must be a whole positive number of bytes");
    end
    if (IDENT_DELAY < CARD_SYNC_LAT + 1 || CMD_RESP_DELAY < CARD_SYNC_LAT + 1) begin
      $error("Answer delay shorter than the input latency");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain declarations
  ccrt_card_state_e st;
  logic lrst_a, lrst_n;
  logic en_s1, en_s2, busy_s1, busy_s2, cmd_s1, cmd_s2;
  logic [47:0] rx_sr;
  logic [5:0] rx_cnt;
  logic [135:0] tx_sr;
  logic [7:0] tx_left;
  logic [7:0] wait_cnt;
  logic od;
  logic xfer_mode;
  logic busy_on;
  logic cmd_o_reg, cmd_oe_reg;
  logic evt_tgl;
  logic [5:0] last_idx;
  logic [31:0] last_arg;
  logic [15:0] relative_address;
  logic [47:0] frame;
  logic frame_ok;
  logic [31:0] status_word;

  // Reset release aligned to the bus clock
  always_ff @(posedge lk.bus_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_a <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_a <= 1'b1;
      lrst_n <= lrst_a;
    end
  end

  // Synchronisers into the link domain
  always_ff @(posedge lk.bus_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {en_s1, en_s2, busy_s1, busy_s2} <= 4'h0;
      {cmd_s1, cmd_s2} <= 2'h3;
    end else begin
      en_s1 <= clk_en;
      en_s2 <= en_s1;
      busy_s1 <= busy_req;
      busy_s2 <= busy_s1;
      cmd_s1 <= lk.cmd_line;
      cmd_s2 <= cmd_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame check on the bit being completed
  assign frame = {rx_sr[46:0], cmd_s2};
  assign frame_ok = frame[47] == START_BIT && frame[46] == TX_HOST &&
    frame[0] == END_BIT && frame[7:1] == ccrt_crc7(frame[47:8]);
  assign status_word = {16'h0, 3'h0, xfer_mode ? ST_TRAN : ST_IDENT, 1'b1, 8'h00};

  // Receive, decide, wait and transmit
  always_ff @(posedge lk.bus_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      st <= CCRT_C_RX;
      rx_sr <= 48'h0;
      rx_cnt <= 6'h00;
      tx_sr <= 136'h0;
      tx_left <= 8'h00;
      wait_cnt <= 8'h00;
      od <= 1'b1;
      xfer_mode <= 1'b0;
      cmd_o_reg <= 1'b1;
      cmd_oe_reg <= 1'b0;
      evt_tgl <= 1'b0;
      last_idx <= 6'h00;
      last_arg <= 32'h0;
      relative_address <= 16'h0;
    end else if (en_s2) begin
      unique case (st)
        CCRT_C_RX: begin
          if (rx_cnt != 6'h00 || cmd_s2 == START_BIT) begin
            rx_sr <= frame;
            rx_cnt <= rx_cnt + 6'h01;
          end
          if (rx_cnt == 6'(CMD_BITS - 1)) begin
            rx_cnt <= 6'h00;
            if (frame_ok) begin
              evt_tgl <= ~evt_tgl;
              last_idx <= frame[45:40];
              last_arg <= frame[39:8];
              if (frame[45:40] == IDX_GO_IDLE) begin
                xfer_mode <= 1'b0;
              end else if (!xfer_mode && frame[45:40] == IDX_OP_COND) begin
                tx_sr <= {START_BIT, TX_CARD, IDX_R2R3, OP_COND_WORD, CRC_NONE, END_BIT,
                  88'h0};
                tx_left <= 8'(CMD_BITS);
                wait_cnt <= 8'(IDENT_DELAY - CARD_SYNC_LAT - 1);
                od <= 1'b1;
                st <= CCRT_C_DELAY;
              end else if (!xfer_mode && frame[45:40] == IDX_IDENT) begin
                tx_sr <= {START_BIT, TX_CARD, IDX_R2R3, IDENT_WORD, END_BIT};
                tx_left <= 8'(LONG_BITS);
                wait_cnt <= 8'(IDENT_DELAY - CARD_SYNC_LAT - 1);
                od <= 1'b1;
                st <= CCRT_C_DELAY;
              end else if (!xfer_mode && frame[45:40] == IDX_ASSIGN_ADDR) begin
                tx_sr <= {ccrt_frame(TX_CARD, frame[45:40], status_word), 88'h0};
                tx_left <= 8'(CMD_BITS);
                wait_cnt <= 8'(CMD_RESP_DELAY - CARD_SYNC_LAT - 1);
                od <= 1'b1;
                relative_address <= frame[39:24];
                xfer_mode <= 1'b1;
                st <= CCRT_C_DELAY;
              end else if (xfer_mode && frame[45:40] != IDX_OP_COND &&
                frame[45:40] != IDX_IDENT && frame[45:40] != IDX_ASSIGN_ADDR) begin
                tx_sr <= {ccrt_frame(TX_CARD, frame[45:40], status_word), 88'h0};
                tx_left <= 8'(CMD_BITS);
                wait_cnt <= 8'(CMD_RESP_DELAY - CARD_SYNC_LAT - 1);
                od <= 1'b0;
                cmd_o_reg <= 1'b1;
                cmd_oe_reg <= 1'b1;
                st <= CCRT_C_DELAY;
              end
            end
          end
        end
        CCRT_C_DELAY: begin
          if (wait_cnt == 8'h00) begin
            cmd_o_reg <= tx_sr[135];
            cmd_oe_reg <= !od || !tx_sr[135];
            tx_sr <= {tx_sr[134:0], 1'b0};
            tx_left <= tx_left - 8'h01;
            st <= CCRT_C_TX;
          end else begin
            wait_cnt <= wait_cnt - 8'h01;
          end
        end
        CCRT_C_TX: begin
          if (tx_left == 8'h00) begin
            cmd_oe_reg <= 1'b0;
            wait_cnt <= 8'(CARD_SYNC_LAT);
            st <= CCRT_C_QUIET;
          end else begin
            cmd_o_reg <= tx_sr[135];
            cmd_oe_reg <= !od || !tx_sr[135];
            tx_sr <= {tx_sr[134:0], 1'b0};
            tx_left <= tx_left - 8'h01;
          end
        end
        CCRT_C_QUIET: begin
          // Own bits still in the input pipeline are not commands
          if (wait_cnt == 8'h00) begin
            st <= CCRT_C_RX;
          end else begin
            wait_cnt <= wait_cnt - 8'h01;
          end
        end
      endcase
    end
  end

  // Busy on the data lines, begun before the check bits are judged
  always_ff @(posedge lk.bus_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      busy_on <= 1'b0;
    end else if (en_s2) begin
      if (st == CCRT_C_RX && rx_cnt == 6'(CMD_BITS - 2) && xfer_mode &&
        rx_sr[43:38] == IDX_SWITCH_FUNC && busy_s2) begin
        busy_on <= 1'b1;
      end else if (st == CCRT_C_RX && rx_cnt == 6'(CMD_BITS - 1) && !frame_ok) begin
        busy_on <= 1'b0;
      end else if (!busy_s2) begin
        busy_on <= 1'b0;
      end
    end
  end

  // Link pin drives
  assign lk.card_cmd_o = cmd_o_reg;
  assign lk.card_cmd_oe = cmd_oe_reg;
  assign lk.card_dat_o = DAT_BUSY_LEVEL;
  assign lk.card_dat_oe = busy_on;

  ////////////////////////////////////////////////////////////////////////////
  // User domain: command event crossing by toggle
  logic tg_s1, tg_s2, tg_s3;
  logic xm_s1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {tg_s1, tg_s2, tg_s3, xm_s1} <= 4'h0;
      transfer_mode <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_index_out <= 6'h00;
      cmd_arg_out <= 32'h0;
      rel_addr_out <= 16'h0;
    end else if (clk_en) begin
      tg_s1 <= evt_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      xm_s1 <= xfer_mode;
      transfer_mode <= xm_s1;
      cmd_strobe <= tg_s2 != tg_s3;
      // Words are stable for a whole frame after each toggle
      if (tg_s2 != tg_s3) begin
        cmd_index_out <= last_idx;
        cmd_arg_out <= last_arg;
        rel_addr_out <= relative_address;
      end
    end
  end

  // Partition sizes from the selected card data set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      erase_group_size <= 16'h0;
      wp_group_size <= 16'h0;
    end else if (clk_en) begin
      erase_group_size <= erase_group_select ? EXT_EG_SIZE : LEG_EG_SIZE;
      wp_group_size <= erase_group_select ? EXT_WP_SIZE : LEG_WP_SIZE;
    end
  end
endmodule
`default_nettype wire

// ### ccrt_pkg.sv
// Purpose: Shared constants, types and frame helpers for the command line link.
// Assumes: Command frames are 48 bits; long identification answers are 136 bits.
// Notes: Delay counts are in bus clock cycles, counted from the command end bit.
package ccrt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame shape and bit symbols
  localparam int CMD_BITS = 48;
  localparam int LONG_BITS = 136;
  localparam int DAT_WIDTH = 8;
  localparam logic START_BIT = 1'b0;
  localparam logic END_BIT = 1'b1;
  localparam logic TX_HOST = 1'b1;
  localparam logic TX_CARD = 1'b0;
  localparam logic [6:0] CRC_NONE = 7'h7f;
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [DAT_WIDTH-1:0] DAT_BUSY_LEVEL = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Command indices
  localparam logic [5:0] IDX_GO_IDLE = 6'h00;
  localparam logic [5:0] IDX_OP_COND = 6'h01;
  localparam logic [5:0] IDX_IDENT = 6'h02;
  localparam logic [5:0] IDX_ASSIGN_ADDR = 6'h03;
  localparam logic [5:0] IDX_SWITCH_FUNC = 6'h06;
  localparam logic [5:0] IDX_R2R3 = 6'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // Timing counts in bus clock cycles
  localparam int IDENT_DELAY = 5;
  localparam int CMD_RESP_DELAY = 5;
  localparam int RESP_CMD_GAP = 8;
  localparam int CMD_CMD_GAP = 8;
  localparam int RESP_TIMEOUT = 64;
  localparam int CARD_SYNC_LAT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Card state field values shown in the status word
  localparam logic [3:0] ST_IDENT = 4'h2;
  localparam logic [3:0] ST_TRAN = 4'h4;

  typedef enum logic [1:0] {CCRT_RESP_NONE, CCRT_RESP_SHORT, CCRT_RESP_LONG,
    CCRT_RESP_BUSY} ccrt_resp_e;

  // Seven bit check over the 40 leading bits of a short frame
  function automatic logic [6:0] ccrt_crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
    end
    return c;
  endfunction

  // Builds start, transmitter, index, argument, check and end bits
  function automatic logic [47:0] ccrt_frame(input logic tx, input logic [5:0] idx,
    input logic [31:0] arg);
    logic [39:0] h;
    h = {START_BIT, tx, idx, arg};
    return {h, ccrt_crc7(h), END_BIT};
  endfunction

endpackage

// ### ccrt_link_if.sv
// Purpose: Bus clock, command line and data lines between host and card.
// Assumes: Lines are wired with pull-ups; any enabled low driver wins.
// Notes: Resolves the command line from the drive enables of both ends, the data lines from the card's.
`timescale 1ns/1ps
`default_nettype none
interface ccrt_link_if;
  import ccrt_pkg::*;
  logic bus_clk;
  logic host_cmd_o;
  logic host_cmd_oe;
  logic card_cmd_o;
  logic card_cmd_oe;
  logic [DAT_WIDTH-1:0] card_dat_o;
  logic card_dat_oe;
  logic cmd_line;
  logic [DAT_WIDTH-1:0] dat_line;

  // Pulled high unless an enabled driver pulls low
  assign cmd_line = !((host_cmd_oe && !host_cmd_o) || (card_cmd_oe && !card_cmd_o));
  assign dat_line = ~({DAT_WIDTH{card_dat_oe}} & ~card_dat_o);

  modport host (output bus_clk, output host_cmd_o, output host_cmd_oe,
    input cmd_line, input dat_line);
  modport card (input bus_clk, input cmd_line, output card_cmd_o,
    output card_cmd_oe, output card_dat_o, output card_dat_oe);
endinterface
`default_nettype wire

// ### ccrt_host.sv
// Purpose: Host end: makes the bus clock, sends commands, collects answers.
// Assumes: One request at a time; the user holds request fields until taken.
// Notes: Bus clock period is twice DIV_HALF system clocks.
`timescale 1ns/1ps
`default_nettype none
module ccrt_host
  import ccrt_pkg::*;
#(
  parameter int DIV_HALF = 2,
  parameter logic [31:0] RELEVANT_MASK = 32'hffffffff
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [5:0] req_index,
  input wire logic [31:0] req_arg,
  input wire ccrt_resp_e req_resp,
  output logic done,
  output logic [127:0] resp_word,
  output logic [31:0] resp_status,
  output logic resp_err,
  output logic no_card,
  ccrt_link_if.host lk
);
  typedef enum logic [2:0] {CCRT_H_IDLE, CCRT_H_SEND, CCRT_H_WAIT, CCRT_H_RECV,
    CCRT_H_BUSY, CCRT_H_GAP} ccrt_host_state_e;

  initial begin
    if (DIV_HALF < 2 || DIV_HALF > 255) begin
      $error("DIV_HALF out of range");
    end
  end

  ccrt_host_state_e st;
  logic [7:0] div_cnt;
  logic clk_reg;
  logic launch;
  logic rise;
  logic cmd_s1, cmd_s2, dat_s1, dat_s2;
  logic cmd_o_reg, cmd_oe_reg;
  logic [47:0] tx_sr;
  logic [135:0] rx_sr;
  logic [135:0] fr;
  logic [7:0] cnt;
  logic [7:0] gap;
  ccrt_resp_e kind;
  logic [5:0] idx_q;
  logic short_ok, long_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock divider; launch follows each rising edge by one clock
  assign rise = (div_cnt == 8'(DIV_HALF - 1)) && !clk_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      clk_reg <= 1'b0;
      launch <= 1'b0;
    end else if (clk_en) begin
      launch <= rise;
      if (div_cnt == 8'(DIV_HALF - 1)) begin
        div_cnt <= 8'h00;
        clk_reg <= ~clk_reg;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Line synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {cmd_s1, cmd_s2, dat_s1, dat_s2} <= 4'hf;
    end else if (clk_en) begin
      cmd_s1 <= lk.cmd_line;
      cmd_s2 <= cmd_s1;
      dat_s1 <= lk.dat_line[0];
      dat_s2 <= dat_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer checks on the frame being completed
  assign fr = {rx_sr[134:0], cmd_s2};
  assign short_ok = fr[47] == START_BIT && fr[46] == TX_CARD && fr[0] == END_BIT &&
    (fr[45:40] == IDX_R2R3 || fr[7:1] == ccrt_crc7(fr[47:8]));
  assign long_ok = fr[135] == START_BIT && fr[134] == TX_CARD && fr[0] == END_BIT;

  // Command sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= CCRT_H_IDLE;
      req_ready <= 1'b1;
      done <= 1'b0;
      resp_word <= 128'h0;
      resp_status <= 32'h0;
      resp_err <= 1'b0;
      no_card <= 1'b0;
      cmd_o_reg <= 1'b1;
      cmd_oe_reg <= 1'b0;
      tx_sr <= 48'h0;
      rx_sr <= 136'h0;
      cnt <= 8'h00;
      gap <= 8'h00;
      kind <= CCRT_RESP_NONE;
      idx_q <= 6'h00;
    end else if (clk_en) begin
      done <= 1'b0;
      unique case (st)
        CCRT_H_IDLE: begin
          if (req_valid && req_ready) begin
            tx_sr <= ccrt_frame(TX_HOST, req_index, req_arg);
            kind <= req_resp;
            idx_q <= req_index;
            cnt <= 8'(CMD_BITS);
            req_ready <= 1'b0;
            no_card <= 1'b0;
            resp_err <= 1'b0;
            st <= CCRT_H_SEND;
          end
        end
        CCRT_H_SEND: begin
          if (launch && cnt != 8'h00) begin
            cmd_o_reg <= tx_sr[47];
            cmd_oe_reg <= 1'b1;
            tx_sr <= {tx_sr[46:0], 1'b0};
            cnt <= cnt - 8'h01;
          end else if (launch) begin
            cmd_oe_reg <= 1'b0;
            if (kind == CCRT_RESP_NONE) begin
              done <= 1'b1;
              gap <= 8'(CMD_CMD_GAP);
              st <= CCRT_H_GAP;
            end else begin
              cnt <= 8'h01;
              st <= CCRT_H_WAIT;
            end
          end
        end
        CCRT_H_WAIT: begin
          if (rise) begin
            cnt <= cnt + 8'h01;
            if (cmd_s2 == START_BIT) begin
              rx_sr <= 136'h0;
              cnt <= (kind == CCRT_RESP_LONG) ? 8'(LONG_BITS - 1) : 8'(CMD_BITS - 1);
              st <= CCRT_H_RECV;
            end else if (idx_q == IDX_IDENT && cnt == 8'(IDENT_DELAY + 1)) begin
              no_card <= 1'b1;
              done <= 1'b1;
              gap <= 8'(CMD_CMD_GAP);
              st <= CCRT_H_GAP;
            end else if (cnt == 8'(RESP_TIMEOUT)) begin
              resp_err <= 1'b1;
              done <= 1'b1;
              gap <= 8'(CMD_CMD_GAP);
              st <= CCRT_H_GAP;
            end
          end
        end
        CCRT_H_RECV: begin
          if (rise) begin
            rx_sr <= fr;
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
              resp_word <= (kind == CCRT_RESP_LONG) ? fr[127:0] : {96'h0, fr[39:8]};
              resp_status <= fr[39:8] & RELEVANT_MASK;
              resp_err <= (kind == CCRT_RESP_LONG) ? !long_ok : !short_ok;
              gap <= 8'(RESP_CMD_GAP);
              if (kind == CCRT_RESP_BUSY) begin
                st <= CCRT_H_BUSY;
              end else begin
                done <= 1'b1;
                st <= CCRT_H_GAP;
              end
            end
          end
        end
        CCRT_H_BUSY: begin
          if (rise && dat_s2) begin
            done <= 1'b1;
            st <= CCRT_H_GAP;
          end
        end
        CCRT_H_GAP: begin
          if (launch) begin
            if (gap <= 8'h01) begin
              req_ready <= 1'b1;
              st <= CCRT_H_IDLE;
            end else begin
              gap <= gap - 8'h01;
            end
          end
        end
      endcase
    end
  end

  // Pin drives
  assign lk.bus_clk = clk_reg;
  assign lk.host_cmd_o = cmd_o_reg;
  assign lk.host_cmd_oe = cmd_oe_reg;
endmodule
`default_nettype wire

// ### ccrt_link_properties.sv
// Purpose: Timing checks on the command and data lines of the link.
// Assumes: Lines are sampled on rising edges of the bus clock.
// Notes: Fixed repeat counts follow the package delay of five periods.
`timescale 1ns/1ps
`default_nettype none
module ccrt_link_properties
  import ccrt_pkg::*;
(
  input wire logic bus_clk,
  input wire logic rst_n,
  input wire logic host_cmd_o,
  input wire logic host_cmd_oe,
  input wire logic card_cmd_oe,
  input wire logic [DAT_WIDTH-1:0] card_dat_o,
  input wire logic card_dat_oe,
  input wire logic cmd_line
);
  logic [7:0] hcnt;
  default clocking @(posedge bus_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////
  // Counts host drive periods of one frame
  always_ff @(posedge bus_clk or negedge rst_n) begin
    if (!rst_n) hcnt <= 8'h00;
    else hcnt <= host_cmd_oe ? hcnt + 8'h01 : 8'h00;
  end
  ////////////////////////////////
  // Host frame shape
  chk_host_start_bit: assert property ($rose(host_cmd_oe) |-> !host_cmd_o)
    else $error("host frame lacks start bit");
  chk_host_tx_bit: assert property ($rose(host_cmd_oe) |=> host_cmd_o)
    else $error("host transmitter bit not one");
  chk_host_frame_len: assert property (
    $fell(host_cmd_oe) |-> hcnt == 8'(CMD_BITS) && $past(host_cmd_o))
    else $error("host frame length or end bit wrong");
  ////////////////////////////////
  // Turnaround and answer placement
  chk_no_contend: assert property (!(host_cmd_oe && card_cmd_oe))
    else $error("both ends drive the command line");
  chk_turn_release: assert property ($fell(host_cmd_oe) |-> !card_cmd_oe[*2])
    else $error("card drives during turnaround");
  chk_resp_min_gap: assert property ($fell(host_cmd_oe) |-> cmd_line[*4])
    else $error("card answer starts too early");
  chk_card_tx_bit: assert property (
    $fell(host_cmd_oe) ##4 !cmd_line |=> !cmd_line)
    else $error("card transmitter bit not zero");
  ////////////////////////////////
  // Busy on data line zero
  chk_busy_start: assert property (
    $rose(card_dat_oe) |-> !$past(host_cmd_oe) && $past(host_cmd_oe, 2))
    else $error("busy not two periods after end bit");
  chk_busy_low: assert property (card_dat_oe |-> card_dat_o[0] == 1'b0)
    else $error("busy does not pull data zero low");
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Runs host requests against the card and checks link timing.
// Assumes: Both ends share one asynchronous reset.
// Notes: A second host with no card checks absence detection.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccrt_pkg::*;
;
  // Identification content; value is arbitrary
  localparam logic [126:0] IDW = 127'h0a5a_0f0f_3c3c_1234_5678_9abc_def0_0001;
  localparam logic [31:0] OPW = 32'h80ff8000;
  localparam logic [31:0] RMASK = 32'hfffffeff;
  logic clock = 1'b0;
  logic clk_b = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] rv = 2'b00;
  logic [5:0] ri [2] = '{default: 6'h00};
  logic [31:0] ra [2] = '{default: 32'h0};
  ccrt_resp_e rr [2] = '{default: CCRT_RESP_NONE};
  logic [1:0] rdy, dn, err, nc;
  logic [127:0] rw;
  logic [31:0] rs;
  logic busy_req = 1'b0;
  logic egs = 1'b0;
  logic tmode;
  logic [5:0] cidx;
  logic [15:0] raddr, egsz, wpsz;
  logic drv1 = 1'b0;
  logic clk_en = 1'b1;
  logic cstb;
  logic [31:0] carg;
  int nstb = 0;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int cnt = 0;
  int idle = 0;
  int lat = -1;
  int first_oe = -1;
  int busy_at = -1;
  ccrt_link_if lk ();
  ccrt_link_if lk_b ();
  ////////////////////////////////
  // Clocks, unrelated in phase
  always #5 clock = ~clock;
  always #6 clk_b = ~clk_b;
  // Absent card: lines released, output pattern toggles
  assign lk_b.card_cmd_oe = 1'b0;
  assign lk_b.card_dat_oe = 1'b0;
  assign lk_b.card_cmd_o = ~lk_b.bus_clk;
  assign lk_b.card_dat_o = {DAT_WIDTH{lk_b.bus_clk}};
  ////////////////////////////////
  // Design ends and checker
  ccrt_host #(.RELEVANT_MASK(RMASK)) i_ccrt_host (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .req_valid(rv[0]), .req_ready(rdy[0]), .req_index(ri[0]),
    .req_arg(ra[0]), .req_resp(rr[0]), .done(dn[0]),
    .resp_word(rw), .resp_status(rs), .resp_err(err[0]), .no_card(nc[0]), .lk(lk.host));
  ccrt_host i_ccrt_host_nocard (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(rv[1]), .req_ready(rdy[1]), .req_index(ri[1]), .req_arg(ra[1]),
    .req_resp(rr[1]), .done(dn[1]), .resp_word(), .resp_status(), .resp_err(err[1]),
    .no_card(nc[1]), .lk(lk_b.host));
  ccrt_card #(.IDENT_WORD(IDW), .OP_COND_WORD(OPW), .LEG_EG_SIZE(16'h0002),
    .EXT_EG_SIZE(16'h0010), .LEG_WP_SIZE(16'h0004), .EXT_WP_SIZE(16'h0008)) i_ccrt_card (
    .clock(clk_b), .rst_n(rst_n), .clk_en(clk_en), .busy_req(busy_req),
    .erase_group_select(egs), .cmd_strobe(cstb), .cmd_index_out(cidx), .cmd_arg_out(carg),
    .rel_addr_out(raddr), .transfer_mode(tmode), .erase_group_size(egsz),
    .wp_group_size(wpsz), .lk(lk.card));
  ccrt_link_properties i_ccrt_link_properties (.bus_clk(lk.bus_clk), .rst_n(rst_n),
    .host_cmd_o(lk.host_cmd_o), .host_cmd_oe(lk.host_cmd_oe), .card_cmd_oe(lk.card_cmd_oe),
    .card_dat_o(lk.card_dat_o), .card_dat_oe(lk.card_dat_oe), .cmd_line(lk.cmd_line));
  ////////////////////////////////
  // Compares and counts
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Answer position, first card drive and driven-high bits
  task tchk(input int l, input int f, input logic d);
    chk(128'(lat), 128'(l));
    chk(128'(first_oe), 128'(f));
    chk(128'(drv1), 128'(d));
  endtask
  // Status word expected for a card state
  function automatic logic [31:0] st(input logic [3:0] s);
    return {16'h0000, 3'h0, s, 1'b1, 8'h00};
  endfunction
  // One request on host h, held until taken, then waits for done
  task send(input int h, input logic [5:0] idx, input logic [31:0] arg,
    input ccrt_resp_e rt);
    @(posedge clock);
    rv[h] <= 1'b1;
    ri[h] <= idx;
    ra[h] <= arg;
    rr[h] <= rt;
    @(negedge clock);
    while (rdy[h] !== 1'b1) @(negedge clock);
    @(posedge clock);
    rv[h] <= 1'b0;
    @(negedge clock);
    while (dn[h] !== 1'b1) @(negedge clock);
    @(posedge clock);
  endtask
  task tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////
  // Times answers, busy and idle gaps on the link
  always @(negedge lk.bus_clk) begin
    if (lk.host_cmd_oe) begin
      if (idle > 0) chk(128'(idle >= RESP_CMD_GAP), 128'h1);
      idle = 0;
      cnt = -1;
      lat = -1;
      first_oe = -1;
      busy_at = -1;
      drv1 = 1'b0;
    end else begin
      cnt++;
      idle = (lk.card_cmd_oe || lk.card_dat_oe || !lk.cmd_line) ? 0 : idle + 1;
      if (lk.card_cmd_oe && first_oe < 0) first_oe = cnt;
      if (lk.card_cmd_oe && lk.card_cmd_o) drv1 = 1'b1;
      if (lk.card_dat_oe && busy_at < 0) busy_at = cnt;
      if (!lk.cmd_line && lat < 0) lat = cnt;
    end
  end
  // Counts accepted command strobes on the card user side
  always @(negedge clk_b) if (cstb === 1'b1) nstb++;
  // Cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (40) @(posedge clock);
    send(0, IDX_OP_COND, 32'h00ff8000, CCRT_RESP_SHORT);
    chk(128'({err[0], rw[31:0]}), 128'(OPW));
    tchk(IDENT_DELAY - 1, IDENT_DELAY - 1, 1'b0);
    send(0, IDX_IDENT, 32'h0, CCRT_RESP_LONG);
    chk(rw, {IDW, 1'b1});
    tchk(IDENT_DELAY - 1, IDENT_DELAY - 1, 1'b0);
    send(0, IDX_ASSIGN_ADDR, 32'h5a5a0000, CCRT_RESP_SHORT);
    chk(128'(rs), 128'(st(ST_IDENT) & RMASK));
    chk(128'({lat >= CMD_RESP_DELAY - 1, drv1}), 128'h2);
    chk(128'({raddr, tmode}), 128'hb4b5);
    send(0, 6'h07, 32'h5a5a0000, CCRT_RESP_SHORT);
    tchk(CMD_RESP_DELAY - 1, 2, 1'b1);
    chk(128'({cidx, carg, rs}), 128'({6'h07, 32'h5a5a0000, st(ST_TRAN) & RMASK}));
    send(0, IDX_OP_COND, 32'h0, CCRT_RESP_SHORT);
    chk(128'(err[0]), 128'h1);
    busy_req <= 1'b1;
    fork
      send(0, IDX_SWITCH_FUNC, 32'h03b70100, CCRT_RESP_BUSY);
      begin
        repeat (400) @(posedge clock);
        busy_req <= 1'b0;
      end
    join
    chk(128'({err[0], busy_at}), 128'h1);
    send(0, IDX_SWITCH_FUNC, 32'h03b70100, CCRT_RESP_BUSY);
    chk(128'(busy_at), 128'(-1));
    send(0, IDX_GO_IDLE, 32'h0, CCRT_RESP_NONE);
    send(0, IDX_OP_COND, 32'h00ff8000, CCRT_RESP_SHORT);
    tchk(IDENT_DELAY - 1, IDENT_DELAY - 1, 1'b0);
    chk(128'(nstb), 128'h9);
    chk(128'({egsz, wpsz}), 128'h00020004);
    clk_en <= 1'b0;
    egs <= 1'b1;
    repeat (8) @(posedge clock);
    chk(128'({egsz, wpsz}), 128'h00020004);
    clk_en <= 1'b1;
    repeat (8) @(posedge clock);
    chk(128'({egsz, wpsz}), 128'h00100008);
    send(1, IDX_IDENT, 32'h0, CCRT_RESP_LONG);
    chk(128'(nc[1]), 128'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
